// [break_entry_defs.svh]
// Vector offsets, mode codes and acknowledge codes for the entry logic.
// Assumes a 32-bit program counter and vector base.
`ifndef BREAK_ENTRY_DEFS_SVH
`define BREAK_ENTRY_DEFS_SVH
`define BRK_VEC_OFS 32'h00000018
`define INT_VEC_OFS 32'h00000010
`define USR_VEC_OFS 32'h00000008
`define BRK_LINK_REG 5'h10
`define INT_LINK_REG 5'h0E
`define ACK_NONE 2'h0
`define ACK_TAKEN 2'h1
`define ACK_RETURN 2'h2
`define ACK_REENABLE 2'h3
`define APB_MSW_ADDR 12'h000
`define APB_STAT_ADDR 12'h004
`define MSW_IE 0
`define MSW_BIP 1
`define MSW_EIP 2
`define MSW_EE 3
`define MSW_UM 4
`define MSW_UMS 5
`define MSW_VM 6
`define MSW_VMS 7
`define MSW_RESET 8'h00
`endif

// [break_entry_pkg.sv]
// Types shared by the entry logic.
// Assumes nothing beyond the defines header.
package break_entry_pkg;
  typedef enum logic [2:0] {
    take_none,
    take_nm_break,
    take_break,
    take_interrupt,
    take_user
  } take_kind_t;
endpackage : break_entry_pkg

// [interrupt_sense.sv]
// Edge or level qualification of the external interrupt request.
// Assumes the request is synchronous to clk.
`timescale 1ns/10ps
module interrupt_sense
(
  input wire logic clk,
  input wire logic rst,
  input wire logic edge_mode,
  input wire logic irq_in,
  input wire logic taken,
  output logic pending
);
  logic irq_prev;
  logic latched;
  wire rise = irq_in & ~irq_prev;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_prev <= 1'b0;
      latched <= 1'b0;
    end
    else
    begin
      irq_prev <= irq_in;
      // latched regardless of enable; a new edge beats the clear
      if (rise)
        latched <= 1'b1;
      else if (taken)
        latched <= 1'b0;
    end
  end

  assign pending = edge_mode ? latched : irq_in;

  a_edge_latch: assert property (@(posedge clk) disable iff (rst)
    edge_mode && irq_in && !irq_prev |=> latched)
    else $error("rising interrupt edge not latched");
endmodule : interrupt_sense

// [break_interrupt_entry.sv]
// Break, interrupt and user vector entry logic with status word over APB.
// Assumes the pipeline supplies decode-stage pc and decoded return ops,
// and completes the execute-stage instruction when redirect is pulsed.
//
// Summary of operation
// - Hardware break redirects decode instruction to base plus 0x18.
// - Break saves decode pc into register 16 and sets break flag.
// - Maskable break acted on only when break and exception flags clear.
// - Non-maskable break is taken at once, whatever the flags.
// - Return from break clears the break-in-progress flag.
// - With debug, immediate break to 0x18 signals debugger, no flag set.
// - Any entry saves and clears user and virtual modes; all but exception entry drop reservation.
// - External interrupt answered only while interrupt enable is one.
// - Interrupt jumps to base plus 0x10 or supplied vector address.
// - Interrupt saves decode pc into register 14 and clears enable.
// - Return from interrupt sets interrupt enable again.
// - No interrupt while break or exception is in progress.
// - Edge mode latches a rising edge; low one cycle before next edge.
// - Edge latched regardless of enable, serviced once enable is set.
// - Vectored mode jumps directly to controller-supplied address.
// - Vectored acknowledge 01 on entry, 10 on return, 11 on re-enable.
// - Each nonzero acknowledge lasts one cycle, then returns to 00 or moves straight to the next code (11 then 01).
// - Branch-link-absolute to 0x8 enters user vector, saves modes.
// - Return from exception restores exception enable and progress bits.
`timescale 1ns/10ps
`include "break_entry_defs.svh"
module break_interrupt_entry
#(
  parameter logic [31:0] vector_base_param = 32'h00000000,
  parameter logic edge_sense_param = 1'b1,
  parameter logic vectored_param = 1'b0,
  parameter logic debug_param = 1'b1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic maskable_break_in,
  input wire logic nonmaskable_break_in,
  input wire logic interrupt_in,
  input wire logic [31:0] interrupt_address,
  input wire logic [31:0] decode_pc,
  input wire logic decode_valid,
  input wire logic return_from_break,
  input wire logic return_from_interrupt,
  input wire logic return_from_exception,
  input wire logic soft_break_0x18,
  input wire logic branch_link_absolute_op,
  input wire logic [4:0] branch_link_reg,
  input wire logic exception_entry,
  input wire logic msw_write,
  input wire logic [7:0] msw_wdata,
  output logic redirect,
  output logic [31:0] redirect_pc,
  output logic link_write,
  output logic [4:0] link_reg,
  output logic [31:0] link_data,
  output logic [1:0] interrupt_ack,
  output logic debug_breakpoint,
  output logic reservation_clear,
  output logic [7:0] machine_status_word
);
  logic [7:0] msw;
  logic [7:0] next_msw;
  logic irq_pending;
  logic [7:0] take_count;
  break_entry_pkg::take_kind_t kind;

  wire break_in_progress = msw[`MSW_BIP];
  wire exception_in_progress = msw[`MSW_EIP];
  wire interrupt_enable_bit = msw[`MSW_IE];
  wire exception_enable_bit = msw[`MSW_EE];
  wire brk_ok = maskable_break_in & ~break_in_progress
    & ~exception_in_progress;
  wire irq_ok = irq_pending & interrupt_enable_bit & ~break_in_progress
    & ~exception_in_progress;
  wire apb_wr = psel & penable & pwrite;
  wire sw_msw_wr = apb_wr & (paddr == `APB_MSW_ADDR);
  wire addr_ok = (paddr == `APB_MSW_ADDR) | (paddr == `APB_STAT_ADDR);

  function automatic logic [7:0] mode_save(input logic [7:0] w);
    logic [7:0] r;
    r = w;
    r[`MSW_UMS] = w[`MSW_UM];
    r[`MSW_UM] = 1'b0;
    r[`MSW_VMS] = w[`MSW_VM];
    r[`MSW_VM] = 1'b0;
    return r;
  endfunction : mode_save

  assign kind = !decode_valid ? break_entry_pkg::take_none :
    nonmaskable_break_in ? break_entry_pkg::take_nm_break :
    brk_ok ? break_entry_pkg::take_break :
    irq_ok ? break_entry_pkg::take_interrupt :
    branch_link_absolute_op ? break_entry_pkg::take_user :
    break_entry_pkg::take_none;

  wire take_irq = (kind == break_entry_pkg::take_interrupt);
  wire take_brk = (kind == break_entry_pkg::take_nm_break) |
    (kind == break_entry_pkg::take_break);
  wire taking = (kind != break_entry_pkg::take_none);

  interrupt_sense u_sense
  (
    .clk(clk),
    .rst(rst),
    .edge_mode(edge_sense_param),
    .irq_in(interrupt_in),
    .taken(take_irq),
    .pending(irq_pending)
  );

  always_comb
  begin
    next_msw = msw;
    if (msw_write)
      next_msw = msw_wdata;
    if (sw_msw_wr)
      next_msw = pwdata[7:0];
    if (return_from_break)
      next_msw[`MSW_BIP] = 1'b0;
    if (return_from_interrupt)
      next_msw[`MSW_IE] = 1'b1;
    if (return_from_exception)
    begin
      next_msw[`MSW_EE] = 1'b1;
      next_msw[`MSW_EIP] = 1'b0;
    end
    if (return_from_break | return_from_interrupt | return_from_exception)
    begin
      next_msw[`MSW_UM] = msw[`MSW_UMS];
      next_msw[`MSW_VM] = msw[`MSW_VMS];
    end
    if (exception_entry)
    begin
      next_msw = mode_save(next_msw);
      next_msw[`MSW_EE] = 1'b0;
      next_msw[`MSW_EIP] = 1'b1;
    end
    if (taking)
      next_msw = mode_save(next_msw);
    if (take_brk)
      next_msw[`MSW_BIP] = 1'b1;
    if (take_irq)
      next_msw[`MSW_IE] = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      msw <= `MSW_RESET;
    else
      msw <= next_msw;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      redirect <= 1'b0;
      redirect_pc <= 32'h00000000;
      link_write <= 1'b0;
      link_reg <= 5'h00;
      link_data <= 32'h00000000;
      reservation_clear <= 1'b0;
    end
    else
    begin
      redirect <= taking;
      link_write <= taking;
      reservation_clear <= taking;
      link_data <= decode_pc;
      if (take_brk)
      begin
        redirect_pc <= vector_base_param + `BRK_VEC_OFS;
        link_reg <= `BRK_LINK_REG;
      end
      else if (take_irq)
      begin
        redirect_pc <= vectored_param ? interrupt_address
          : vector_base_param + `INT_VEC_OFS;
        link_reg <= `INT_LINK_REG;
      end
      else
      begin
        redirect_pc <= vector_base_param + `USR_VEC_OFS;
        link_reg <= branch_link_reg;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      interrupt_ack <= `ACK_NONE;
    else if (!vectored_param)
      interrupt_ack <= `ACK_NONE;
    else if (take_irq)
      interrupt_ack <= `ACK_TAKEN;
    else if (return_from_interrupt)
      interrupt_ack <= `ACK_RETURN;
    else if (!msw[`MSW_IE] && next_msw[`MSW_IE])
      interrupt_ack <= `ACK_REENABLE;
    else
      interrupt_ack <= `ACK_NONE;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      debug_breakpoint <= 1'b0;
    else
      debug_breakpoint <= debug_param & soft_break_0x18;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      take_count <= 8'h00;
    else if (taking)
      take_count <= take_count + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= (paddr == `APB_MSW_ADDR) ? {24'h000000, msw}
        : (paddr == `APB_STAT_ADDR) ? {22'h000000, irq_pending,
        interrupt_in, take_count} : 32'h00000000;
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign machine_status_word = msw;

  a_brk_mask: assert property (@(posedge clk) disable iff (rst)
    decode_valid && maskable_break_in && !nonmaskable_break_in
    && (break_in_progress || exception_in_progress)
    && !irq_ok && !branch_link_absolute_op |=> !redirect)
    else $error("masked break was taken");
  a_nm_take: assert property (@(posedge clk) disable iff (rst)
    decode_valid && nonmaskable_break_in |=> redirect
    && redirect_pc == vector_base_param + `BRK_VEC_OFS
    && link_reg == `BRK_LINK_REG)
    else $error("non-maskable break not taken");
  a_bip_set: assert property (@(posedge clk) disable iff (rst)
    take_brk && !exception_entry |=> break_in_progress)
    else $error("break flag not set");
  a_irq_block: assert property (@(posedge clk) disable iff (rst)
    (break_in_progress || exception_in_progress) && interrupt_enable_bit
    && !msw_write && !sw_msw_wr |=> interrupt_enable_bit)
    else $error("interrupt taken during break");
  a_ie_clear: assert property (@(posedge clk) disable iff (rst)
    take_irq |=> !interrupt_enable_bit && link_reg == `INT_LINK_REG
    && link_data == $past(decode_pc))
    else $error("interrupt entry state wrong");
  a_ack_pulse: assert property (@(posedge clk) disable iff (rst)
    interrupt_ack == `ACK_TAKEN |=> interrupt_ack != `ACK_TAKEN)
    else $error("acknowledge held too long");
  a_mode_save: assert property (@(posedge clk) disable iff (rst)
    taking && !msw_write && !sw_msw_wr |=> !msw[`MSW_UM] && !msw[`MSW_VM]
    && msw[`MSW_UMS] == $past(msw[`MSW_UM]))
    else $error("mode bits not saved on entry");
  a_bip_clear: assert property (@(posedge clk) disable iff (rst)
    return_from_break && !take_brk && !msw_write && !sw_msw_wr
    |=> !break_in_progress)
    else $error("break flag not cleared");
  a_brk_vector: assert property (@(posedge clk) disable iff (rst)
    kind == break_entry_pkg::take_break |=> redirect
    && redirect_pc == vector_base_param + `BRK_VEC_OFS
    && link_data == $past(decode_pc))
    else $error("maskable break vector wrong");
  a_int_vector: assert property (@(posedge clk) disable iff (rst)
    take_irq |=> redirect && link_reg == `INT_LINK_REG
    && redirect_pc == (vectored_param ? $past(interrupt_address)
    : vector_base_param + `INT_VEC_OFS))
    else $error("interrupt vector wrong");
  a_user_vector: assert property (@(posedge clk) disable iff (rst)
    kind == break_entry_pkg::take_user |=> redirect
    && redirect_pc == vector_base_param + `USR_VEC_OFS
    && link_reg == $past(branch_link_reg))
    else $error("user vector entry wrong");
  a_irq_gate: assert property (@(posedge clk) disable iff (rst)
    !interrupt_enable_bit |=> interrupt_ack != `ACK_TAKEN)
    else $error("interrupt taken while disabled");
  a_ie_return: assert property (@(posedge clk) disable iff (rst)
    return_from_interrupt && !take_irq && !msw_write && !sw_msw_wr
    |=> interrupt_enable_bit)
    else $error("interrupt enable not restored");
  a_ack_codes: assert property (@(posedge clk) disable iff (rst)
    vectored_param && return_from_interrupt && !take_irq
    |=> interrupt_ack == `ACK_RETURN)
    else $error("return acknowledge missing");
  a_dbg_nobip: assert property (@(posedge clk) disable iff (rst)
    soft_break_0x18 && !break_in_progress && !take_brk
    && !msw_write && !sw_msw_wr
    |=> debug_breakpoint == debug_param && !break_in_progress)
    else $error("software breakpoint handling wrong");
  a_brk_first: assert property (@(posedge clk) disable iff (rst)
    decode_valid && (nonmaskable_break_in || brk_ok) |=> redirect
    && redirect_pc == vector_base_param + `BRK_VEC_OFS)
    else $error("break lost priority");
  a_eip_restore: assert property (@(posedge clk) disable iff (rst)
    return_from_exception && !exception_entry && !msw_write && !sw_msw_wr
    |=> exception_enable_bit && !exception_in_progress)
    else $error("exception return did not restore flags");
endmodule : break_interrupt_entry

// [break_source_model.sv]
// Far side: break requester and vectored interrupt controller.
// Assumes go_* are one-cycle commands from the bench.
`timescale 1ns/10ps
module break_source_model
(
  input wire logic clk,
  input wire logic go_brk,
  input wire logic go_nm,
  input wire logic go_irq,
  input wire logic go_lvl,
  input wire logic redirect,
  input wire logic level_taken,
  output logic maskable_break_in,
  output logic nonmaskable_break_in,
  output logic interrupt_in,
  output logic level_interrupt_in,
  output logic [31:0] interrupt_address
);
  initial
  begin
    maskable_break_in = 1'h0;
    nonmaskable_break_in = 1'h0;
    interrupt_in = 1'h0;
    level_interrupt_in = 1'h0;
    interrupt_address = 32'h00002000;
  end
  always @(posedge clk)
  begin
    if (go_brk)
      maskable_break_in <= 1'h1;
    else if (redirect)
      maskable_break_in <= 1'h0;
    nonmaskable_break_in <= go_nm;
    interrupt_in <= go_irq;
    if (go_lvl)
      level_interrupt_in <= 1'h1;
    else if (level_taken)
      level_interrupt_in <= 1'h0;
  end
endmodule : break_source_model

// [tb_top.sv]
// Bench for break, interrupt and user vector entry.
// Assumes zero-wait APB and one-cycle answers from the block.
`timescale 1ns/10ps
module tb_top;
  localparam logic [31:0] base = 32'h00001000;
  localparam logic [31:0] hv = 32'h00002000;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, dpc, rpc, ldata, iaddr, rd;
  logic mb, nb, irq, red, lw, dbg, rclr;
  logic dv, mw, lg, lirq, red2;
  logic [31:0] rpc2, ldata2;
  logic [4:0] lreg2, blr;
  logic [1:0] ack2;
  logic [7:0] mwd;
  logic [2:0] gg;
  logic [5:0] pp;
  logic [4:0] lreg;
  logic [1:0] ack;
  logic [7:0] msw;
  logic [1:0] acks[$];
  int n_errors = 0;
  int n_compared = 0;
  break_source_model u_src (.clk(clk), .go_brk(gg[0]), .go_nm(gg[1]),
    .go_irq(gg[2]), .go_lvl(lg), .redirect(red), .level_taken(red2),
    .maskable_break_in(mb), .nonmaskable_break_in(nb), .interrupt_in(irq),
    .level_interrupt_in(lirq), .interrupt_address(iaddr));
  break_interrupt_entry #(.vector_base_param(base), .edge_sense_param(1'h1),
    .vectored_param(1'h1), .debug_param(1'h1)) u_dut (.clk(clk), .rst(rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .maskable_break_in(mb), .nonmaskable_break_in(nb), .interrupt_in(irq),
    .interrupt_address(iaddr), .decode_pc(dpc), .decode_valid(dv),
    .return_from_break(pp[0]), .return_from_interrupt(pp[1]),
    .return_from_exception(pp[2]), .soft_break_0x18(pp[3]),
    .branch_link_absolute_op(pp[4]), .branch_link_reg(blr),
    .exception_entry(pp[5]), .msw_write(mw), .msw_wdata(mwd),
    .redirect(red), .redirect_pc(rpc), .link_write(lw), .link_reg(lreg),
    .link_data(ldata), .interrupt_ack(ack), .debug_breakpoint(dbg),
    .reservation_clear(rclr), .machine_status_word(msw));
  // Level-sensed, base-vectored copy on the same bus and pipeline
  break_interrupt_entry #(.vector_base_param(base), .edge_sense_param(1'h0),
    .vectored_param(1'h0)) u_lvl (.clk(clk), .rst(rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(), .pready(), .pslverr(), .maskable_break_in(mb),
    .nonmaskable_break_in(nb), .interrupt_in(lirq),
    .interrupt_address(iaddr), .decode_pc(dpc), .decode_valid(dv),
    .return_from_break(pp[0]), .return_from_interrupt(pp[1]),
    .return_from_exception(pp[2]), .soft_break_0x18(pp[3]),
    .branch_link_absolute_op(pp[4]), .branch_link_reg(blr),
    .exception_entry(pp[5]), .msw_write(mw), .msw_wdata(mwd),
    .redirect(red2), .redirect_pc(rpc2), .link_write(), .link_reg(lreg2),
    .link_data(ldata2), .interrupt_ack(ack2), .debug_breakpoint(),
    .reservation_clear(), .machine_status_word());
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // Logged one edge late, so repeated codes show up as duplicates
  always @(posedge clk)
    if (ack !== 2'h0)
      acks.push_back(ack);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do
      @(posedge clk);
    while (pready !== 1'h1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic gpulse(input logic [2:0] m);
    @(posedge clk);
    gg <= m;
    @(posedge clk);
    gg <= 3'h0;
  endtask : gpulse
  task automatic ppulse(input logic [5:0] m);
    @(posedge clk);
    pp <= m;
    @(posedge clk);
    pp <= 6'h00;
  endtask : ppulse
  task automatic wred(input logic [31:0] pc, input logic [4:0] r,
    input logic [31:0] d);
    int i;
    i = 0;
    #1;
    while (red !== 1'h1 && i < 10)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    chk({31'h0, red}, 32'h1);
    chk(rpc, pc);
    chk({lw, 26'h0, lreg}, {1'h1, 26'h0, r});
    chk(ldata, d);
  endtask : wred
  task automatic quiet(input int n);
    repeat (n)
    begin
      @(posedge clk);
      #1;
      chk({31'h0, red}, 32'h0);
    end
  endtask : quiet
  task automatic wlvl(input logic [31:0] pc, input logic [31:0] d);
    int i;
    i = 0;
    #1;
    while (red2 !== 1'h1 && i < 10)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    chk({31'h0, red2}, 32'h1);
    chk(rpc2, pc);
    chk({27'h0, lreg2}, 32'h0000000E);
    chk(ldata2, d);
    chk({30'h0, ack2}, 32'h0);
  endtask : wlvl
  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  initial
  begin
    #40000;
    $display("FAIL %0t watchdog expired", $time);
    n_errors++;
    summarize();
  end
  initial
  begin
    rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    gg = 3'h0;
    pp = 6'h00;
    dpc = 32'h00000100;
    dv = 1'h1;
    mw = 1'h0;
    mwd = 8'h00;
    blr = 5'h0F;
    lg = 1'h0;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 12'h008, 32'h0);
    chk({perr, rd[30:0]}, 32'h80000000);
    $display("test reset done");
    gpulse(3'h2);
    wred(base + 32'h18, 5'h10, 32'h100);
    chk({31'h0, rclr}, 32'h1);
    chk({24'h0, msw}, 32'h00000002);
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h2);
    dpc <= 32'h00000104;
    gpulse(3'h2);
    wred(base + 32'h18, 5'h10, 32'h104);
    gpulse(3'h1);
    quiet(6);
    ppulse(6'h01);
    wred(base + 32'h18, 5'h10, 32'h104);
    ppulse(6'h01);
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    $display("test break done");
    apb(1'h1, 12'h000, 32'h50);
    ppulse(6'h10);
    wred(base + 32'h8, 5'h0F, 32'h104);
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'hA0);
    ppulse(6'h08);
    #1;
    chk({31'h0, dbg}, 32'h1);
    apb(1'h0, 12'h000, 32'h0);
    chk({31'h0, rd[1]}, 32'h0);
    apb(1'h1, 12'h000, 32'h0);
    gpulse(3'h4);
    quiet(4);
    apb(1'h0, 12'h004, 32'h0);
    chk(rd, 32'h00000204);
    acks.delete();
    apb(1'h1, 12'h000, 32'h1);
    wred(hv, 5'h0E, 32'h104);
    apb(1'h0, 12'h000, 32'h0);
    chk({31'h0, rd[0]}, 32'h0);
    chk({30'h0, acks[0]}, 32'h3);
    chk({30'h0, acks[1]}, 32'h1);
    chk(32'(acks.size()), 32'h2);
    ppulse(6'h02);
    apb(1'h0, 12'h000, 32'h0);
    chk({31'h0, rd[0]}, 32'h1);
    chk({30'h0, acks[2]}, 32'h2);
    $display("test interrupt done");
    gpulse(3'h6);
    wred(base + 32'h18, 5'h10, 32'h104);
    quiet(3);
    ppulse(6'h01);
    wred(hv, 5'h0E, 32'h104);
    ppulse(6'h02);
    ppulse(6'h20);
    gpulse(3'h1);
    quiet(4);
    ppulse(6'h04);
    wred(base + 32'h18, 5'h10, 32'h104);
    ppulse(6'h01);
    $display("test priority done");
    dv <= 1'h0;
    gpulse(3'h1);
    quiet(4);
    @(posedge clk);
    dv <= 1'h1;
    wred(base + 32'h18, 5'h10, 32'h104);
    ppulse(6'h01);
    mwd <= 8'h05;
    mw <= 1'h1;
    @(posedge clk);
    mw <= 1'h0;
    lg <= 1'h1;
    @(posedge clk);
    lg <= 1'h0;
    repeat (3)
    begin
      @(posedge clk);
      #1;
      chk({31'h0, red2}, 32'h0);
    end
    chk({31'h0, lirq}, 32'h1);
    ppulse(6'h04);
    wlvl(base + 32'h10, 32'h104);
    $display("test level done");
    summarize();
  end
endmodule : tb_top
